// ---- hw/wutss_top.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Reload value is 16 bits, low byte write-only
// - Tick with counter already at zero while running and armed raises wake event
// - Counter steps once per prescaler tick
// - Flag-clear bit clears timeout and cold-start flags
// - Flag-clear register bit 1 enables RC calibration
// - Status bit 6 shows calibration fault
// - Status bit 5 shows calibration finished
// - Status bit 4 shows crystal settled
// - Status bit 3 shows live crystal level
// - Status bit 2 holds cold-start until cleared
// - Status bit 1 latches timeout until cleared
// - Status bit 0 is live counter-at-zero
// - Shutdown request acts only with chip select high
// - High byte takes effect on next low write
// - Arm bit gates wake on timeout
// - Config bit 4 selects RC or crystal tick
module wutss_top #(
  parameter int RELOAD_W = wutss_pkg::RELOAD_W_DOC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire wutss_pkg::wutss_addr_t reg_addr,
  input  wire wutss_pkg::wutss_data_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output wutss_pkg::wutss_data_t reg_rdata,
  input  wire logic              rc_32k_level,
  input  wire logic              crystal_32k_raw_level,
  input  wire logic              crystal_32k_settled,
  input  wire logic              rc_osc_cal_done,
  input  wire logic              rc_osc_cal_fault,
  input  wire logic              cold_start_event,
  input  wire logic              chip_select,
  output logic                   rc_osc_cal_enable,
  output logic                   rc_32k_enable,
  output logic                   crystal_32k_enable,
  output logic                   timeout_live_event,
  output logic                   wake_request,
  output logic                   shutdown_start
);
  import wutss_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (RELOAD_W != 2 * DATA_W) begin : g_bad_width
      $error("reload width must be two register bytes");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  wutss_presc_t        presc_sel_reg,  presc_sel_next;
  logic                arm_reg,        arm_next;
  logic                clksel_reg,     clksel_next;
  logic                xtal_en_reg,    xtal_en_next;
  logic                rc_en_reg,      rc_en_next;
  wutss_data_t         val_high_reg,   val_high_next;
  logic [RELOAD_W-1:0] reload_reg,     reload_next;
  logic [RELOAD_W-1:0] count_reg,      count_next;
  logic                clr_flags_reg,  clr_flags_next;
  logic                cal_en_reg,     cal_en_next;
  logic                shdn_req_reg,   shdn_req_next;
  wutss_data_t         rdata_reg,      rdata_next;
  logic                wake_reg,       wake_next;
  logic                shdn_start_reg, shdn_start_next;

  logic                wr_low;
  logic                running;
  logic                at_zero;
  logic                timeout_evt;
  logic                cold_flag;
  logic                to_flag;
  wutss_data_t         status_byte;

  wutss_tick_if tick_bus ();

  // ----------------------------------------------------------------
  // Tick source and prescaler
  // ----------------------------------------------------------------
  // Source oscillator chosen by the clock-select bit
  assign tick_bus.presc_sel = presc_sel_reg;
  assign tick_bus.src_level = clksel_reg ? rc_32k_level : crystal_32k_raw_level;

  wutss_presc u_presc (
    .clk   (ref_clk),
    .rst_n (rst_sync_reg),
    .tk    (tick_bus.presc)
  );

  // ----------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------
  // Unit runs while its selected oscillator is enabled
  assign wr_low      = reg_wr && (reg_addr == OFS_VAL_LOW);
  assign running     = clksel_reg ? rc_en_reg : xtal_en_reg;
  assign at_zero     = (count_reg == '0);
  assign timeout_evt = tick_bus.tick && running && at_zero && !wr_low;

  // Load on low write, else step on each tick
  always_comb begin
    reload_next = reload_reg;
    count_next  = count_reg;
    if (wr_low) begin
      reload_next = {val_high_reg, reg_wdata};
      count_next  = {val_high_reg, reg_wdata};
    end else if (tick_bus.tick && running) begin
      if (at_zero) begin
        count_next = reload_reg;
      end else begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reload_reg <= '0;
      count_reg  <= '0;
    end else begin
      reload_reg <= reload_next;
      count_reg  <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // Timeout latch, cleared by the flag-clear bit
  wutss_sticky u_to_flag (
    .clk       (ref_clk),
    .rst_n     (rst_sync_reg),
    .set_pulse (timeout_evt),
    .clear     (clr_flags_reg),
    .flag      (to_flag)
  );

  // Cold-start latch, cleared by the same bit
  wutss_sticky u_cold_flag (
    .clk       (ref_clk),
    .rst_n     (rst_sync_reg),
    .set_pulse (cold_start_event),
    .clear     (clr_flags_reg),
    .flag      (cold_flag)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Decode writes into the control fields
  always_comb begin
    presc_sel_next = presc_sel_reg;
    arm_next       = arm_reg;
    clksel_next    = clksel_reg;
    xtal_en_next   = xtal_en_reg;
    rc_en_next     = rc_en_reg;
    val_high_next  = val_high_reg;
    clr_flags_next = clr_flags_reg;
    cal_en_next    = cal_en_reg;
    shdn_req_next  = shdn_req_reg;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CFG_HIGH: begin
          presc_sel_next = reg_wdata[PRESC_LSB +: PRESC_W];
        end
        OFS_CFG_LOW: begin
          arm_next     = reg_wdata[CFG_ARM_BIT];
          clksel_next  = reg_wdata[CFG_CLKSEL_BIT];
          xtal_en_next = reg_wdata[CFG_XTAL_EN_BIT];
          rc_en_next   = reg_wdata[CFG_RC_EN_BIT];
        end
        OFS_VAL_HIGH: begin
          val_high_next = reg_wdata;
        end
        OFS_FLAG_CAL: begin
          clr_flags_next = reg_wdata[CLR_FLAGS_BIT];
          cal_en_next    = reg_wdata[CAL_EN_BIT];
        end
        OFS_SHUTDOWN: begin
          shdn_req_next = reg_wdata[SHDN_REQ_BIT];
        end
        default: begin
          shdn_req_next = shdn_req_reg;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      presc_sel_reg <= RST_BYTE[PRESC_W-1:0];
      arm_reg       <= 1'b0;
      clksel_reg    <= 1'b0;
      xtal_en_reg   <= 1'b0;
      rc_en_reg     <= 1'b0;
      val_high_reg  <= RST_BYTE;
      clr_flags_reg <= 1'b0;
      cal_en_reg    <= 1'b0;
      shdn_req_reg  <= 1'b0;
    end else begin
      presc_sel_reg <= presc_sel_next;
      arm_reg       <= arm_next;
      clksel_reg    <= clksel_next;
      xtal_en_reg   <= xtal_en_next;
      rc_en_reg     <= rc_en_next;
      val_high_reg  <= val_high_next;
      clr_flags_reg <= clr_flags_next;
      cal_en_reg    <= cal_en_next;
      shdn_req_reg  <= shdn_req_next;
    end
  end

  // ----------------------------------------------------------------
  // Status and read-back
  // ----------------------------------------------------------------
  // Status byte; calibration and settle bits gated by their enables
  always_comb begin
    status_byte               = RST_BYTE;
    status_byte[ST_CAL_FAULT] = cal_en_reg & rc_osc_cal_fault;
    status_byte[ST_CAL_DONE]  = cal_en_reg & rc_osc_cal_done;
    status_byte[ST_XTAL_RDY]  = xtal_en_reg & crystal_32k_settled;
    status_byte[ST_XTAL_LVL]  = crystal_32k_raw_level;
    status_byte[ST_COLD]      = cold_flag;
    status_byte[ST_TO_LATCH]  = to_flag;
    status_byte[ST_TO_LIVE]   = at_zero;
  end

  // Read mux; write-only and unmapped offsets read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      case (reg_addr)
        OFS_FLAG_CAL: begin
          rdata_next = RST_BYTE;
          rdata_next[CLR_FLAGS_BIT] = clr_flags_reg;
          rdata_next[CAL_EN_BIT]    = cal_en_reg;
        end
        OFS_STATUS: begin
          rdata_next = status_byte;
        end
        OFS_SHUTDOWN: begin
          rdata_next = RST_BYTE;
          rdata_next[SHDN_REQ_BIT] = shdn_req_reg;
        end
        default: begin
          rdata_next = RST_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake and shutdown outputs
  // ----------------------------------------------------------------
  // Wake only when armed; shutdown only with chip select high
  always_comb begin
    wake_next       = timeout_evt & arm_reg;
    shdn_start_next = shdn_req_reg & chip_select;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata_reg      <= RST_BYTE;
      wake_reg       <= 1'b0;
      shdn_start_reg <= 1'b0;
    end else begin
      rdata_reg      <= rdata_next;
      wake_reg       <= wake_next;
      shdn_start_reg <= shdn_start_next;
    end
  end

  assign reg_rdata          = rdata_reg;
  assign wake_request       = wake_reg;
  assign shutdown_start     = shdn_start_reg;
  assign timeout_live_event = at_zero;
  assign rc_osc_cal_enable  = cal_en_reg;
  assign rc_32k_enable      = rc_en_reg;
  assign crystal_32k_enable = xtal_en_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RELOAD_PAIR: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    wr_low |=> (reload_reg == {$past(val_high_reg), $past(reg_wdata)}))
    else $error("reload not built from high then low byte");
  AST_STEP_ON_TICK: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    (tick_bus.tick && running && !at_zero && !wr_low) |=> (count_reg == $past(count_reg) - 1'b1))
    else $error("counter did not step on tick");
  AST_HOLD_NO_TICK: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    (!tick_bus.tick && !wr_low) |=> $stable(count_reg))
    else $error("counter moved without a tick");
  AST_RELOAD_AT_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    timeout_evt |=> (count_reg == $past(reload_reg)))
    else $error("counter did not reload after zero");
  AST_WAKE_ARMED: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    wake_reg |-> ($past(arm_reg) && $past(at_zero) && $past(tick_bus.tick)))
    else $error("wake without armed timeout");
  AST_WAKE_ON_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    (timeout_evt && arm_reg) |=> wake_reg ##1 !wake_reg)
    else $error("armed timeout gave no single wake pulse");
  AST_LATCH_SET: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    timeout_evt |=> to_flag) else $error("timeout not latched");
  AST_LIVE_READ: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    (reg_rd && reg_addr == OFS_STATUS) |=> (reg_rdata[ST_TO_LIVE] == $past(at_zero)))
    else $error("live timeout bit wrong");
  AST_CAL_GATED: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    (reg_rd && reg_addr == OFS_STATUS && !cal_en_reg) |=> (reg_rdata[ST_CAL_FAULT:ST_CAL_DONE] == 2'h0))
    else $error("calibration bits visible while disabled");
  AST_SHDN_CS: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    shdn_start_reg |-> ($past(chip_select) && $past(shdn_req_reg)))
    else $error("shutdown started without chip select");
endmodule

// ---- hw/wutss_pkg.sv ----
package wutss_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  typedef logic [ADDR_W-1:0] wutss_addr_t;
  typedef logic [DATA_W-1:0] wutss_data_t;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam wutss_addr_t OFS_CFG_HIGH  = 10'h30c;
  localparam wutss_addr_t OFS_CFG_LOW   = 10'h30d;
  localparam wutss_addr_t OFS_VAL_HIGH  = 10'h30e;
  localparam wutss_addr_t OFS_VAL_LOW   = 10'h30f;
  localparam wutss_addr_t OFS_FLAG_CAL  = 10'h310;
  localparam wutss_addr_t OFS_STATUS    = 10'h311;
  localparam wutss_addr_t OFS_SHUTDOWN  = 10'h322;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CLR_FLAGS_BIT   = 0;
  localparam int CAL_EN_BIT      = 1;
  localparam int ST_CAL_FAULT    = 6;
  localparam int ST_CAL_DONE     = 5;
  localparam int ST_XTAL_RDY     = 4;
  localparam int ST_XTAL_LVL     = 3;
  localparam int ST_COLD         = 2;
  localparam int ST_TO_LATCH     = 1;
  localparam int ST_TO_LIVE      = 0;
  localparam int CFG_ARM_BIT     = 0;
  localparam int CFG_CLKSEL_BIT  = 4;
  localparam int CFG_XTAL_EN_BIT = 5;
  localparam int CFG_RC_EN_BIT   = 6;
  localparam int SHDN_REQ_BIT    = 0;
  localparam int PRESC_LSB       = 0;
  localparam int PRESC_W         = 3;
  localparam int RELOAD_W_DOC    = 16;

  localparam wutss_data_t RST_BYTE = 8'h00;

  typedef logic [PRESC_W-1:0] wutss_presc_t;

  // ----------------------------------------------------------------
  // Prescaler terminal counts (divider minus one)
  // ----------------------------------------------------------------
  function automatic logic [15:0] wutss_presc_tc(input wutss_presc_t sel);
    logic [15:0] tc;
    case (sel)
      3'h0:    tc = 16'h0000;
      3'h1:    tc = 16'h0003;
      3'h2:    tc = 16'h0007;
      3'h3:    tc = 16'h000f;
      3'h4:    tc = 16'h007f;
      3'h5:    tc = 16'h03ff;
      3'h6:    tc = 16'h1fff;
      default: tc = 16'hffff;
    endcase
    return tc;
  endfunction

endpackage

// ---- hw/wutss_tick_if.sv ----
`timescale 1ns/10ps
interface wutss_tick_if;
  wutss_pkg::wutss_presc_t presc_sel;
  logic                    src_level;
  logic                    tick;

  modport core  (output presc_sel, output src_level, input  tick);
  modport presc (input  presc_sel, input  src_level, output tick);
endinterface

// ---- hw/wutss_sticky.sv ----
`timescale 1ns/10ps
module wutss_sticky (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_pulse,
  input  wire logic clear,
  output logic      flag
);
  import wutss_pkg::*;

  logic flag_reg;
  logic flag_next;

  // Set wins over a clear in the same cycle
  always_comb begin
    flag_next = set_pulse | (flag_reg & ~clear);
  end

  // Flag register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    set_pulse |=> flag_reg) else $error("sticky flag lost a set");
  AST_HOLD_UNTIL_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (flag_reg && !clear) |=> flag_reg) else $error("sticky flag dropped without clear");
endmodule

// ---- hw/wutss_presc.sv ----
`timescale 1ns/10ps
module wutss_presc (
  input  wire logic  clk,
  input  wire logic  rst_n,
  wutss_tick_if.presc tk
);
  import wutss_pkg::*;

  logic        prev_reg;
  logic        prev_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;
  logic        edge_32k;

  // Divide 32 kHz rising edges by the selected ratio
  always_comb begin
    edge_32k  = tk.src_level & ~prev_reg;
    prev_next = tk.src_level;
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (edge_32k) begin
      if (cnt_reg >= wutss_presc_tc(tk.presc_sel)) begin
        cnt_next  = 16'h0000;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  // Divider state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tk.tick = tick_reg;

  AST_TICK_FROM_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
    tick_reg |-> $past(edge_32k)) else $error("tick without a 32k edge");
  AST_DIV1_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    (edge_32k && tk.presc_sel == 3'h0) |=> tick_reg) else $error("divide-by-one missed edge");
endmodule

// ---- tb/wutss_host_model.sv ----
`timescale 1ns/10ps
// --------------------------------------------------------------
// Host controller on the register port
// --------------------------------------------------------------
module wutss_host_model (
  input  wire logic                   ref_clk,
  output wutss_pkg::wutss_addr_t      reg_addr,
  output wutss_pkg::wutss_data_t      reg_wdata,
  output logic                        reg_wr,
  output logic                        reg_rd,
  input  wire wutss_pkg::wutss_data_t reg_rdata,
  output logic                        chip_select
);
  import wutss_pkg::*;

  // Idle port at time zero
  initial begin
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chip_select = 1'b0;
  end

  // One write strobe; released lines never keep the last value
  task automatic wr(input wutss_addr_t a, input wutss_data_t d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // One read strobe; data is taken in the cycle after the strobe
  task automatic rd(input wutss_addr_t a, output wutss_data_t d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // Reload value goes high byte first, low byte last
  task automatic load(input logic [15:0] v);
    wr(OFS_VAL_HIGH, v[15:8]);
    wr(OFS_VAL_LOW, v[7:0]);
  endtask

  // Serial chip select level
  task automatic set_cs(input logic v);
    @(negedge ref_clk);
    chip_select = v;
  endtask
endmodule

// ---- tb/wutss_top_tb_top.sv ----
`timescale 1ns/10ps
module wutss_top_tb_top;
  import wutss_pkg::*;

  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  wutss_addr_t reg_addr;
  wutss_data_t reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  wutss_data_t reg_rdata;
  logic        chip_select;
  logic        rc_32k_level = 1'b0;
  logic        crystal_32k_raw_level = 1'b0;
  logic        crystal_32k_settled = 1'b0;
  logic        rc_osc_cal_done = 1'b0;
  logic        rc_osc_cal_fault = 1'b0;
  logic        cold_start_event = 1'b0;
  logic        rc_osc_cal_enable;
  logic        rc_32k_enable;
  logic        crystal_32k_enable;
  logic        timeout_live_event;
  logic        wake_request;
  logic        shutdown_start;
  logic [7:0]  wake_n = 8'h00;
  int          bad_count = 0;
  int          n_checks = 0;

  wutss_top dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rc_32k_level(rc_32k_level), .crystal_32k_raw_level(crystal_32k_raw_level),
    .crystal_32k_settled(crystal_32k_settled), .rc_osc_cal_done(rc_osc_cal_done),
    .rc_osc_cal_fault(rc_osc_cal_fault), .cold_start_event(cold_start_event),
    .chip_select(chip_select), .rc_osc_cal_enable(rc_osc_cal_enable),
    .rc_32k_enable(rc_32k_enable), .crystal_32k_enable(crystal_32k_enable),
    .timeout_live_event(timeout_live_event), .wake_request(wake_request),
    .shutdown_start(shutdown_start)
  );

  wutss_host_model host (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_select(chip_select)
  );

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  // Count wake pulses
  always @(posedge ref_clk) begin
    if (wake_request === 1'b1) begin
      wake_n <= wake_n + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // Checking helpers
  // --------------------------------------------------------------
  task automatic chk(input wutss_data_t got, input wutss_data_t exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  task automatic rchk(input wutss_addr_t a, input wutss_data_t exp);
    wutss_data_t v;
    host.rd(a, v);
    chk(v, exp);
  endtask

  // Rising edges on one oscillator level, five cycles each
  task automatic osc(input logic rc, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      rc_32k_level          = rc ? 1'b1 : rc_32k_level;
      crystal_32k_raw_level = rc ? crystal_32k_raw_level : 1'b1;
      repeat (2) @(negedge ref_clk);
      rc_32k_level          = rc ? 1'b0 : rc_32k_level;
      crystal_32k_raw_level = rc ? crystal_32k_raw_level : 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    chk({3'h0, rc_osc_cal_enable, rc_32k_enable, crystal_32k_enable, wake_request,
         shutdown_start}, 8'h00);
    rchk(OFS_STATUS, 8'h01);
    rchk(OFS_VAL_LOW, 8'h00);
    rchk(OFS_FLAG_CAL, 8'h00);
    rchk(OFS_SHUTDOWN, 8'h00);
    host.wr(OFS_STATUS, 8'hff);
    rchk(OFS_STATUS, 8'h01);
    rchk(10'h3ff, 8'h00);
  endtask

  task automatic t_timer;
    host.wr(OFS_CFG_HIGH, 8'h00);
    host.wr(OFS_CFG_LOW, 8'h51);
    host.load(16'h0002);
    osc(1'b1, 1);
    chkb(timeout_live_event, 1'b0);
    osc(1'b1, 1);
    chkb(timeout_live_event, 1'b1);
    rchk(OFS_STATUS, 8'h01);
    osc(1'b1, 1);
    chk(wake_n, 8'h01);
    chkb(timeout_live_event, 1'b0);
    rchk(OFS_STATUS, 8'h02);
    // Divide by four: eight edges make two ticks, one timeout
    host.wr(OFS_CFG_HIGH, 8'h01);
    host.load(16'h0001);
    osc(1'b1, 8);
    chk(wake_n, 8'h02);
    host.wr(OFS_CFG_HIGH, 8'h00);
    host.wr(OFS_VAL_HIGH, 8'h01);
    osc(1'b1, 1);
    chkb(timeout_live_event, 1'b1);
    host.wr(OFS_VAL_LOW, 8'h00);
    chkb(timeout_live_event, 1'b0);
  endtask

  task automatic t_source;
    // RC selected but disabled: ticks must not move the counter
    host.wr(OFS_CFG_LOW, 8'h10);
    host.load(16'h0001);
    osc(1'b1, 1);
    chkb(timeout_live_event, 1'b0);
    host.wr(OFS_CFG_LOW, 8'h20);
    host.load(16'h0001);
    osc(1'b1, 2);
    chkb(timeout_live_event, 1'b0);
    osc(1'b0, 1);
    chkb(timeout_live_event, 1'b1);
    osc(1'b0, 1);
    chk(wake_n, 8'h02);
  endtask

  task automatic t_flags;
    host.wr(OFS_CFG_LOW, 8'h70);
    chkb(rc_32k_enable, 1'b1);
    chkb(crystal_32k_enable, 1'b1);
    @(negedge ref_clk);
    cold_start_event = 1'b1;
    crystal_32k_settled = 1'b1;
    crystal_32k_raw_level = 1'b1;
    rc_osc_cal_done = 1'b1;
    rc_osc_cal_fault = 1'b1;
    @(negedge ref_clk);
    cold_start_event = 1'b0;
    host.wr(OFS_FLAG_CAL, 8'h02);
    chkb(rc_osc_cal_enable, 1'b1);
    rchk(OFS_FLAG_CAL, 8'h02);
    rchk(OFS_STATUS, 8'h7e);
    host.wr(OFS_FLAG_CAL, 8'h03);
    host.wr(OFS_FLAG_CAL, 8'h02);
    rchk(OFS_STATUS, 8'h78);
    @(negedge ref_clk);
    crystal_32k_raw_level = 1'b0;
    host.wr(OFS_FLAG_CAL, 8'h00);
    rchk(OFS_STATUS, 8'h10);
  endtask

  task automatic t_shutdown;
    host.set_cs(1'b0);
    host.wr(OFS_SHUTDOWN, 8'h01);
    @(negedge ref_clk);
    chkb(shutdown_start, 1'b0);
    rchk(OFS_SHUTDOWN, 8'h01);
    host.set_cs(1'b1);
    @(negedge ref_clk);
    chkb(shutdown_start, 1'b1);
    host.wr(OFS_SHUTDOWN, 8'h00);
    @(negedge ref_clk);
    chkb(shutdown_start, 1'b0);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_timer();
    t_source();
    t_flags();
    t_shutdown();
    stop_test();
  end

  // Watchdog: the run needs about 175 cycles, allow over a hundred times that
  initial begin
    #2_000_000;
    bad_count++;
    stop_test();
  end
endmodule
